// ==== verilog/mpwf_top.sv ====
// Page walk, domain and permission checking, fault recording
// Functional notes
// - Second-level code 00 gives page translation fault
// - Code 01 decodes a 64-Kbyte large page
// - Code 10 decodes a 4-Kbyte small page
// - Code 11 is reserved, page translation fault
// - Bit 2 bufferable, used with write buffer on
// - Bit 3 cacheable, used with cache on
// - Bits 11:4 hold four subpage permission fields
// - Address quarter selects field, top uses highest
// - Page number from 31:12 small, 31:16 large
// - Section permissions checked before physical address
// - Page permissions checked; table base from descriptor
// - Any fault aborts access and informs core
// - Violations detected first, memory access suppressed
// - Data abort records code, domain and address
// - Prefetch abort only flags, records stay unchanged
// - Highest priority fault code is recorded
// - Section translation domain from bits 8:5
// - Domain register holds sixteen two-bit fields
// - Descriptor bits 8:5 select the domain field
// - Domain field 00 raises domain fault
// - Domain field 01 client, permissions checked
// - Domain field 10 acts as no access
// - Domain field 11 manager, no permission check
// - Misaligned data word raises alignment fault
//
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module mpwf_top (
  input  wire logic                clk_i,
  input  wire logic                reset_i,
  // Avalon-MM register slave
  input  wire logic [3:0]          avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_writedata_i,
  input  wire logic [3:0]          avs_byteenable_i,
  output logic [31:0]              avs_readdata_o,
  output logic                     avs_waitrequest_o,
  output logic [1:0]               avs_response_o,
  // Core access request and answer
  input  wire logic                core_req_i,
  input  wire mpwf_pkg::mpwf_req_t core_req_data_i,
  output logic                     core_done_o,
  output mpwf_pkg::mpwf_resp_t     core_resp_o,
  output logic                     core_prefetch_abort_o,
  // Translation table read port
  output logic                     tbl_read_o,
  output logic [31:0]              tbl_addr_o,
  input  wire logic                tbl_valid_i,
  input  wire logic [31:0]         tbl_rdata_i,
  // Table base pointer value, written by the core's coprocessor path
  input  wire logic                base_wr_i,
  input  wire logic [31:0]         base_wdata_i
);

  // ------------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------------
  logic [31:0]          domain_access_control_r, domain_access_control_nxt;
  logic [7:0]           fault_status_record_r, fault_status_record_nxt;
  logic [31:0]          fault_address_record_r, fault_address_record_nxt;
  logic [31:0]          table_base_pointer_r, table_base_pointer_nxt;
  logic [3:0]           control_r, control_nxt;
  logic                 control_sys_r, control_sys_nxt;
  logic                 control_rom_r, control_rom_nxt;
  logic                 rd_ack_r, rd_ack_nxt;
  logic [31:0]          rdata_r, rdata_nxt;
  logic [1:0]           resp_r, resp_nxt;
  logic                 rec_en;
  logic [7:0]           rec_value;
  logic                 hit_reg;

  // ------------------------------------------------------------------
  // Walk state
  // ------------------------------------------------------------------
  mpwf_pkg::mpwf_state_t state_r, state_nxt;
  mpwf_pkg::mpwf_req_t   req_r, req_nxt;
  mpwf_pkg::mpwf_resp_t  resp_out_r, resp_out_nxt;
  logic [31:0]           l1_r, l1_nxt;
  logic                  tbl_read_r, tbl_read_nxt;
  logic [31:0]           tbl_addr_r, tbl_addr_nxt;
  logic                  done_r, done_nxt;
  logic                  pabort_r, pabort_nxt;

  // Shared decode of the current descriptors
  logic [3:0]  dom_num;
  logic [1:0]  dom_field;
  logic [1:0]  sub_perm;
  logic        sec_deny;
  logic        sub_deny;
  logic        misaligned;

  assign hit_reg = (avs_address_i == mpwf_pkg::ADDR_DOMAIN_CTRL)
                || (avs_address_i == mpwf_pkg::ADDR_FAULT_STATUS)
                || (avs_address_i == mpwf_pkg::ADDR_FAULT_ADDR)
                || (avs_address_i == mpwf_pkg::ADDR_CONTROL);

  // Writes finish at once; reads wait one cycle so data come from a flop
  assign avs_waitrequest_o = avs_read_i && !rd_ack_r;
  assign avs_readdata_o    = rdata_r;
  assign avs_response_o    = resp_r;

  // Bus next-state logic; fault capture has priority over nothing, records are read-only
  always_comb begin
    domain_access_control_nxt = domain_access_control_r;
    table_base_pointer_nxt    = table_base_pointer_r;
    control_nxt               = control_r;
    control_sys_nxt           = control_sys_r;
    control_rom_nxt           = control_rom_r;
    fault_status_record_nxt   = fault_status_record_r;
    fault_address_record_nxt  = fault_address_record_r;
    rd_ack_nxt                = avs_read_i && !rd_ack_r;
    rdata_nxt                 = rdata_r;
    resp_nxt                  = resp_r;
    if (avs_write_i) begin
      resp_nxt = hit_reg ? 2'h0 : 2'h2;
      if (avs_address_i == mpwf_pkg::ADDR_DOMAIN_CTRL) begin
        for (int b = 0; b < 4; b++) begin
          if (avs_byteenable_i[b]) begin
            domain_access_control_nxt[b*8 +: 8] = avs_writedata_i[b*8 +: 8];
          end
        end
      end
      if (avs_address_i == mpwf_pkg::ADDR_CONTROL) begin
        if (avs_byteenable_i[0]) begin
          control_nxt = avs_writedata_i[3:0];
        end
        if (avs_byteenable_i[1]) begin
          control_sys_nxt = avs_writedata_i[mpwf_pkg::CTL_SYS_BIT];
          control_rom_nxt = avs_writedata_i[mpwf_pkg::CTL_ROM_BIT];
        end
      end
    end
    if (avs_read_i && !rd_ack_r) begin
      resp_nxt  = hit_reg ? 2'h0 : 2'h2;
      rdata_nxt = 32'h0000_0000;
      unique case (avs_address_i)
        mpwf_pkg::ADDR_DOMAIN_CTRL:  rdata_nxt = domain_access_control_r;
        mpwf_pkg::ADDR_FAULT_STATUS: rdata_nxt = {24'h000000, fault_status_record_r};
        mpwf_pkg::ADDR_FAULT_ADDR:   rdata_nxt = fault_address_record_r;
        mpwf_pkg::ADDR_CONTROL: begin
          rdata_nxt = {22'h000000, control_rom_r, control_sys_r, 4'h0, control_r};
        end
        default:                     rdata_nxt = 32'h0000_0000;
      endcase
    end
    if (base_wr_i) begin
      table_base_pointer_nxt = {base_wdata_i[31:mpwf_pkg::TABLE_BASE_LSB], 14'h0000};
    end
    if (rec_en) begin
      fault_status_record_nxt  = rec_value;
      fault_address_record_nxt = req_r.vaddr;
    end
  end

  // Register file flops
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      domain_access_control_r <= mpwf_pkg::DOMAIN_CTRL_RST;
      table_base_pointer_r    <= mpwf_pkg::TABLE_BASE_RST;
      control_r               <= mpwf_pkg::CONTROL_RST;
      control_sys_r           <= 1'b0;
      control_rom_r           <= 1'b0;
      fault_status_record_r   <= mpwf_pkg::FAULT_STATUS_RST;
      fault_address_record_r  <= mpwf_pkg::FAULT_ADDR_RST;
      rd_ack_r                <= 1'b0;
      rdata_r                 <= 32'h0000_0000;
      resp_r                  <= 2'h0;
    end else begin
      domain_access_control_r <= domain_access_control_nxt;
      table_base_pointer_r    <= table_base_pointer_nxt;
      control_r               <= control_nxt;
      control_sys_r           <= control_sys_nxt;
      control_rom_r           <= control_rom_nxt;
      fault_status_record_r   <= fault_status_record_nxt;
      fault_address_record_r  <= fault_address_record_nxt;
      rd_ack_r                <= rd_ack_nxt;
      rdata_r                 <= rdata_nxt;
      resp_r                  <= resp_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Descriptor decode
  // ------------------------------------------------------------------
  // Domain number always from the first-level entry, even when invalid
  assign dom_num   = l1_r[8:5];
  assign dom_field = domain_access_control_r[{dom_num, 1'b0} +: 2];
  // Large pages pick the quarter by VA 15:14, small pages by VA 11:10
  assign sub_perm  = (tbl_rdata_i[1:0] == mpwf_pkg::L2_LARGE)
                   ? tbl_rdata_i[4 + {req_r.vaddr[15:14], 1'b0} +: 2]
                   : tbl_rdata_i[4 + {req_r.vaddr[11:10], 1'b0} +: 2];
  assign misaligned = control_r[mpwf_pkg::CTL_ALIGN_EN] && req_r.data_word
                   && (req_r.vaddr[1:0] != 2'h0);

  mpwf_perm_check u_sec_perm (
    .perm_i    (l1_r[11:10]),
    .sys_bit_i (control_sys_r),
    .rom_bit_i (control_rom_r),
    .user_i    (req_r.user),
    .write_i   (req_r.write),
    .deny_o    (sec_deny)
  );

  mpwf_perm_check u_sub_perm (
    .perm_i    (sub_perm),
    .sys_bit_i (control_sys_r),
    .rom_bit_i (control_rom_r),
    .user_i    (req_r.user),
    .write_i   (req_r.write),
    .deny_o    (sub_deny)
  );

  // ------------------------------------------------------------------
  // Walk machine
  // ------------------------------------------------------------------
  assign tbl_read_o            = tbl_read_r;
  assign tbl_addr_o            = tbl_addr_r;
  assign core_done_o           = done_r;
  assign core_resp_o           = resp_out_r;
  assign core_prefetch_abort_o = pabort_r;

  // Faults end the walk before any access is issued; the translated
  // address is only released when every check has passed
  always_comb begin
    state_nxt    = state_r;
    req_nxt      = req_r;
    resp_out_nxt = resp_out_r;
    l1_nxt       = l1_r;
    tbl_read_nxt = tbl_read_r;
    tbl_addr_nxt = tbl_addr_r;
    done_nxt     = 1'b0;
    pabort_nxt   = 1'b0;
    rec_en       = 1'b0;
    rec_value    = 8'h00;
    unique case (state_r)
      mpwf_pkg::ST_IDLE: begin
        if (core_req_i) begin
          req_nxt   = core_req_data_i;
          state_nxt = mpwf_pkg::ST_DONE;
        end
      end
      mpwf_pkg::ST_DONE: begin
        // First cycle after capture: alignment, then start the walk
        resp_out_nxt = '0;
        if (misaligned) begin
          resp_out_nxt.abort      = 1'b1;
          resp_out_nxt.fault_code = mpwf_pkg::FC_ALIGN;
          state_nxt = mpwf_pkg::ST_IDLE;
          done_nxt  = 1'b1;
        end else if (!control_r[mpwf_pkg::CTL_MMU_EN]) begin
          resp_out_nxt.paddr = req_r.vaddr; // Flat mapping
          state_nxt = mpwf_pkg::ST_IDLE;
          done_nxt  = 1'b1;
        end else begin
          tbl_read_nxt = 1'b1;
          tbl_addr_nxt = {table_base_pointer_r[31:14], req_r.vaddr[31:20], 2'h0};
          state_nxt    = mpwf_pkg::ST_L1;
        end
      end
      mpwf_pkg::ST_L1: begin
        if (tbl_valid_i) begin
          tbl_read_nxt = 1'b0;
          l1_nxt       = tbl_rdata_i;
          state_nxt    = mpwf_pkg::ST_L2;
          if (tbl_rdata_i[1:0] == mpwf_pkg::L1_PAGE) begin
            // Second fetch uses the page table base from the descriptor
            tbl_read_nxt = 1'b1;
            tbl_addr_nxt = {tbl_rdata_i[31:10], req_r.vaddr[19:12], 2'h0};
          end
        end
      end
      mpwf_pkg::ST_L2: begin
        // Checks are ordered from highest to lowest priority
        done_nxt = 1'b1;
        state_nxt = mpwf_pkg::ST_IDLE;
        resp_out_nxt.abort = 1'b1;
        if (l1_r[1:0] == mpwf_pkg::L1_SECTION) begin
          if (dom_field == mpwf_pkg::DOM_NONE || dom_field == mpwf_pkg::DOM_RESV) begin
            resp_out_nxt.fault_code = mpwf_pkg::FC_SEC_DOM;
          end else if (dom_field == mpwf_pkg::DOM_CLIENT && sec_deny) begin
            resp_out_nxt.fault_code = mpwf_pkg::FC_SEC_PERM;
          end else begin
            resp_out_nxt.abort      = 1'b0;
            resp_out_nxt.paddr      = {l1_r[31:20], req_r.vaddr[19:0]};
            resp_out_nxt.cacheable  = l1_r[3] && control_r[mpwf_pkg::CTL_CACHE_EN];
            resp_out_nxt.bufferable = l1_r[2] && control_r[mpwf_pkg::CTL_WBUF_EN];
          end
        end else if (l1_r[1:0] != mpwf_pkg::L1_PAGE) begin
          resp_out_nxt.fault_code = mpwf_pkg::FC_SEC_TRANS;
        end else if (!tbl_valid_i) begin
          // Waiting for the second-level entry
          done_nxt           = 1'b0;
          state_nxt          = mpwf_pkg::ST_L2;
          resp_out_nxt.abort = 1'b0;
        end else begin
          tbl_read_nxt = 1'b0;
          if (tbl_rdata_i[1:0] == mpwf_pkg::L2_INVALID ||
              tbl_rdata_i[1:0] == mpwf_pkg::L2_RESV) begin
            resp_out_nxt.fault_code = mpwf_pkg::FC_PG_TRANS;
          end else if (dom_field == mpwf_pkg::DOM_NONE || dom_field == mpwf_pkg::DOM_RESV) begin
            resp_out_nxt.fault_code = mpwf_pkg::FC_PG_DOM;
          end else if (dom_field == mpwf_pkg::DOM_CLIENT && sub_deny) begin
            resp_out_nxt.fault_code = mpwf_pkg::FC_PG_PERM;
          end else begin
            resp_out_nxt.abort = 1'b0;
            if (tbl_rdata_i[1:0] == mpwf_pkg::L2_LARGE) begin
              resp_out_nxt.paddr = {tbl_rdata_i[31:16], req_r.vaddr[15:0]};
            end else begin
              resp_out_nxt.paddr = {tbl_rdata_i[31:12], req_r.vaddr[11:0]};
            end
            resp_out_nxt.bufferable = tbl_rdata_i[2] && control_r[mpwf_pkg::CTL_WBUF_EN];
            resp_out_nxt.cacheable  = tbl_rdata_i[3] && control_r[mpwf_pkg::CTL_CACHE_EN];
          end
        end
      end
      default: begin
        state_nxt = mpwf_pkg::ST_IDLE;
      end
    endcase
    // Data aborts are recorded, prefetch aborts only flag the fetch
    if (done_nxt && resp_out_nxt.abort) begin
      if (req_r.instr) begin
        pabort_nxt = 1'b1;
      end else begin
        rec_en    = 1'b1;
        rec_value = {dom_num, resp_out_nxt.fault_code};
      end
    end
  end

  // Walk flops
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r    <= mpwf_pkg::ST_IDLE;
      req_r      <= '0;
      resp_out_r <= '0;
      l1_r       <= 32'h0000_0000;
      tbl_read_r <= 1'b0;
      tbl_addr_r <= 32'h0000_0000;
      done_r     <= 1'b0;
      pabort_r   <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      req_r      <= req_nxt;
      resp_out_r <= resp_out_nxt;
      l1_r       <= l1_nxt;
      tbl_read_r <= tbl_read_nxt;
      tbl_addr_r <= tbl_addr_nxt;
      done_r     <= done_nxt;
      pabort_r   <= pabort_nxt;
    end
  end

endmodule

`default_nettype wire

// ==== verilog/mpwf_pkg.sv ====
// Package: constants, states and carriers of the page walk and fault unit
package mpwf_pkg;

  // ------------------------------------------------------------------
  // Register map, byte addresses on the Avalon-MM slave
  // ------------------------------------------------------------------
  localparam logic [3:0]  ADDR_DOMAIN_CTRL  = 4'h0;
  localparam logic [3:0]  ADDR_FAULT_STATUS = 4'h4;
  localparam logic [3:0]  ADDR_FAULT_ADDR   = 4'h8;
  localparam logic [3:0]  ADDR_CONTROL      = 4'hC;
  localparam logic [31:0] DOMAIN_CTRL_RST   = 32'h0000_0000;
  localparam logic [7:0]  FAULT_STATUS_RST  = 8'h00;
  localparam logic [31:0] FAULT_ADDR_RST    = 32'h0000_0000;
  localparam logic [31:0] TABLE_BASE_RST    = 32'h0000_0000;
  localparam logic [3:0]  CONTROL_RST       = 4'h0;
  // Control register bit positions
  localparam int CTL_MMU_EN   = 0;
  localparam int CTL_ALIGN_EN = 1;
  localparam int CTL_CACHE_EN = 2;
  localparam int CTL_WBUF_EN  = 3;
  localparam int CTL_SYS_BIT  = 8;
  localparam int CTL_ROM_BIT  = 9;
  localparam int TABLE_BASE_LSB = 14;

  // ------------------------------------------------------------------
  // Descriptor encodings and fault codes
  // ------------------------------------------------------------------
  localparam logic [1:0] L1_PAGE    = 2'h1;
  localparam logic [1:0] L1_SECTION = 2'h2;
  localparam logic [1:0] L2_INVALID = 2'h0;
  localparam logic [1:0] L2_LARGE   = 2'h1;
  localparam logic [1:0] L2_SMALL   = 2'h2;
  localparam logic [1:0] L2_RESV    = 2'h3;
  localparam logic [1:0] DOM_NONE   = 2'h0;
  localparam logic [1:0] DOM_CLIENT = 2'h1;
  localparam logic [1:0] DOM_RESV   = 2'h2;
  localparam logic [1:0] DOM_MGR    = 2'h3;
  localparam logic [3:0] FC_ALIGN     = 4'h1;
  localparam logic [3:0] FC_SEC_TRANS = 4'h5;
  localparam logic [3:0] FC_PG_TRANS  = 4'h7;
  localparam logic [3:0] FC_SEC_DOM   = 4'h9;
  localparam logic [3:0] FC_PG_DOM    = 4'hB;
  localparam logic [3:0] FC_SEC_PERM  = 4'hD;
  localparam logic [3:0] FC_PG_PERM   = 4'hF;

  // Walk states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_L1   = 3'b001,
    ST_L2   = 3'b010,
    ST_DONE = 3'b011
  } mpwf_state_t;

  // Core request carrier
  typedef struct packed {
    logic [31:0] vaddr;
    logic        write;
    logic        user;
    logic        data_word;
    logic        instr;
  } mpwf_req_t;

  // Translation result carrier
  typedef struct packed {
    logic [31:0] paddr;
    logic        cacheable;
    logic        bufferable;
    logic        abort;
    logic [3:0]  fault_code;
  } mpwf_resp_t;

endpackage

// ==== verilog/mpwf_perm_check.sv ====
// Access permission check of one two-bit permission field
`timescale 1ns/1ps
`default_nettype none

module mpwf_perm_check (
  input  wire logic [1:0] perm_i,
  input  wire logic       sys_bit_i,
  input  wire logic       rom_bit_i,
  input  wire logic       user_i,
  input  wire logic       write_i,
  output logic            deny_o
);

  // Permission field decode; reserved system/rom combination denies all
  always_comb begin
    deny_o = 1'b0;
    unique case (perm_i)
      2'h0: begin
        if (sys_bit_i && rom_bit_i) begin
          deny_o = 1'b1;
        end else if (sys_bit_i) begin
          deny_o = user_i || write_i;
        end else if (rom_bit_i) begin
          deny_o = write_i;
        end else begin
          deny_o = 1'b1;
        end
      end
      2'h1: deny_o = user_i;
      2'h2: deny_o = user_i && write_i;
      2'h3: deny_o = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

// ==== dv/mpwf_asserts.sv ====
// Port-level checks of the page walk and fault unit
`timescale 1ns/1ps
`default_nettype none
module mpwf_asserts (
  input wire logic                 clk_i,
  input wire logic                 reset_i,
  input wire logic                 avs_read_i,
  input wire logic                 avs_waitrequest_o,
  input wire logic                 core_done_o,
  input wire mpwf_pkg::mpwf_resp_t core_resp_o,
  input wire logic                 core_prefetch_abort_o,
  input wire logic                 tbl_read_o,
  input wire logic [31:0]          tbl_addr_o,
  input wire logic                 tbl_valid_i
);
  // One clock domain, so clocking and reset are given once
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  property p_rd_ans; avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_tbl_hold; tbl_read_o && !tbl_valid_i |=> tbl_read_o && $stable(tbl_addr_o); endproperty
  a_tbl_hold: assert property (p_tbl_hold) else $error("table read dropped");
  property p_done_pulse; core_done_o |=> !core_done_o; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
  property p_code_odd; core_done_o && core_resp_o.abort |-> core_resp_o.fault_code[0]; endproperty
  a_code_odd: assert property (p_code_odd) else $error("bad fault code");
  property p_pref; core_prefetch_abort_o |-> core_done_o && core_resp_o.abort; endproperty
  a_pref: assert property (p_pref) else $error("stray prefetch abort");
  // Misalignment must be caught before any table cycle starts
  property p_align;
    core_done_o && core_resp_o.fault_code == mpwf_pkg::FC_ALIGN |-> !$past(tbl_read_o, 2);
  endproperty
  a_align: assert property (p_align) else $error("table read on misaligned access");
  property p_sec_tr;
    core_done_o && core_resp_o.fault_code == mpwf_pkg::FC_SEC_TRANS |-> $past(tbl_valid_i, 2);
  endproperty
  a_sec_tr: assert property (p_sec_tr) else $error("section fault timing");
  property p_pg_tr;
    core_done_o && core_resp_o.fault_code == mpwf_pkg::FC_PG_TRANS |-> $past(tbl_valid_i);
  endproperty
  a_pg_tr: assert property (p_pg_tr) else $error("page fault timing");
endmodule
`default_nettype wire

// ==== dv/mpwf_tbl_model.sv ====
// Translation table memory answering the walk, prompt or slow
`timescale 1ns/1ps
`default_nettype none
module mpwf_tbl_model (
  input  wire logic        clk_i,
  input  wire logic        slow_i,
  input  wire logic        rd_i,
  input  wire logic [31:0] addr_i,
  output logic             valid_o,
  output logic [31:0]      rdata_o
);
  logic [31:0] mem [logic [31:0]];
  int          cnt;
  initial begin
    valid_o = 1'b0;
    rdata_o = 32'h0;
    cnt = 0;
  end
  // Missing entries read as zero; released data is inverted so stale bits never match
  always @(posedge clk_i) begin
    if (valid_o) begin
      valid_o <= 1'b0;
      rdata_o <= ~rdata_o;
      cnt <= 0;
    end else if (rd_i) begin
      if (cnt >= (slow_i ? 5 : 0)) begin
        valid_o <= 1'b1;
        rdata_o <= mem.exists(addr_i) ? mem[addr_i] : 32'h0;
      end else cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench of the page walk and fault unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {logic [31:0] dac, l1, l2, va; logic [3:0] code; logic [31:0] pa;
                  logic [1:0] cb;} mpwf_row_t;
  localparam logic [31:0] VA = 32'h0030_5678;
  localparam logic [31:0] P  = 32'h0002_0031;
  logic                 clk_i = 1'b0, reset_i = 1'b1;
  logic [3:0]           addr = 4'h0;
  logic                 rd = 1'b0, wr = 1'b0, bwr = 1'b0, req = 1'b0, slow = 1'b0;
  logic [31:0]          wdata = 32'h0, bwd = 32'h0, rdv, readdata, taddr, trdata;
  logic [1:0]           rsp, response;
  logic                 waitreq, done, pabt, tread, tvalid;
  mpwf_pkg::mpwf_req_t  rq = '0;
  mpwf_pkg::mpwf_resp_t resp;
  int                   miscompares = 0, cmp_count = 0;
  // Ordinary cases: domain, level one, level two, address, code, address out, cache bits
  mpwf_row_t rows [14] = '{
    '{32'h4, 32'h0040_0C32, 32'h0, VA, 4'h0, 32'h0040_5678, 2'b00},
    '{32'h4, 32'h0040_0032, 32'h0, VA, 4'hD, 32'h0, 2'b00},
    '{32'h0, 32'h0040_0C32, 32'h0, VA, 4'h9, 32'h0, 2'b00},
    '{32'h8, 32'h0040_0C32, 32'h0, VA, 4'h9, 32'h0, 2'b00},
    '{32'h4, 32'h0000_01E0, 32'h0, VA, 4'h5, 32'h0, 2'b00},
    '{32'h4, P, 32'h0ABC_DFFE, VA, 4'h0, 32'h0ABC_D678, 2'b11},
    '{32'h4, P, 32'h0AB0_0FF1, VA, 4'h0, 32'h0AB0_5678, 2'b00},
    '{32'h4, P, 32'h0ABC_DFF0, VA, 4'h7, 32'h0, 2'b00},
    '{32'h4, P, 32'h0ABC_DFF3, VA, 4'h7, 32'h0, 2'b00},
    '{32'h0, P, 32'h0ABC_DFFE, VA, 4'hB, 32'h0, 2'b00},
    '{32'h4, P, 32'h0ABC_DF32, VA, 4'hF, 32'h0, 2'b00},
    '{32'h4, P, 32'h0AB0_0F31, VA, 4'hF, 32'h0, 2'b00},
    '{32'hC, P, 32'h0ABC_DF32, VA, 4'h0, 32'h0ABC_D678, 2'b00},
    '{32'h4, 32'h0, 32'h0, VA + 1, 4'h1, 32'h0, 2'b00}};
  mpwf_top uut (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
    .avs_readdata_o(readdata), .avs_waitrequest_o(waitreq), .avs_response_o(response),
    .core_req_i(req), .core_req_data_i(rq), .core_done_o(done), .core_resp_o(resp),
    .core_prefetch_abort_o(pabt), .tbl_read_o(tread), .tbl_addr_o(taddr),
    .tbl_valid_i(tvalid), .tbl_rdata_i(trdata), .base_wr_i(bwr), .base_wdata_i(bwd));
  mpwf_tbl_model u_mem (.clk_i(clk_i), .slow_i(slow), .rd_i(tread), .addr_i(taddr),
    .valid_o(tvalid), .rdata_o(trdata));
  // ----------------------------------------------------------
  // Clock, tasks and watchdog
  // ----------------------------------------------------------
  initial forever #20 clk_i = ~clk_i;
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a; wdata <= d; wr <= 1'b1;
    do @(posedge clk_i); while (waitreq !== 1'b0);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [3:0] a);
    @(posedge clk_i);
    addr <= a; rd <= 1'b1;
    do @(posedge clk_i); while (waitreq !== 1'b0);
    rdv = readdata; rsp = response;
    rd <= 1'b0;
  endtask
  // Waits are bounded so a silent unit shows up as a miscompare, not a hang
  task automatic core(input logic [31:0] va, input logic ins);
    int n;
    @(posedge clk_i);
    req <= 1'b1;
    rq <= '{vaddr: va, write: 1'b0, user: 1'b0, data_word: ~ins, instr: ins};
    @(posedge clk_i);
    req <= 1'b0;
    n = 0;
    do begin @(posedge clk_i); n++; end while (done !== 1'b1 && n < 200);
    chk("done", done, 1'b1);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    end_sim();
  end
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    bwr <= 1'b1; bwd <= 32'h0001_0000;
    @(posedge clk_i);
    bwr <= 1'b0;
    bus_wr(mpwf_pkg::ADDR_CONTROL, 32'h0000_000F);
    foreach (rows[i]) begin
      slow <= i[0];
      bus_wr(mpwf_pkg::ADDR_DOMAIN_CTRL, rows[i].dac);
      u_mem.mem.delete();
      u_mem.mem[32'h0001_000C] = rows[i].l1;
      // Large entries fill all sixteen slots that share the page
      for (int k = 0; k < 16; k++)
        if (rows[i].l2[1:0] == 2'b01 || k == 5)
          u_mem.mem[32'h0002_0000 + 4 * k] = rows[i].l2;
      core(rows[i].va, 1'b0);
      chk("abort", resp.abort, rows[i].code != 4'h0);
      chk("code", resp.fault_code, rows[i].code);
      chk("no_pabt", pabt, 1'b0);
      if (rows[i].code == 4'h0) begin
        chk("paddr", resp.paddr, rows[i].pa);
        chk("cache", {resp.cacheable, resp.bufferable}, rows[i].cb);
      end else begin
        bus_rd(mpwf_pkg::ADDR_FAULT_STATUS);
        chk("fs_code", rdv[3:0], rows[i].code);
        if (rows[i].code != 4'h1) chk("fs_dom", rdv[7:4], rows[i].l1[8:5]);
        bus_rd(mpwf_pkg::ADDR_FAULT_ADDR);
        chk("fault_addr", rdv, rows[i].va);
      end
    end
    // Prefetch abort must leave the records of the last data abort alone
    bus_wr(mpwf_pkg::ADDR_DOMAIN_CTRL, 32'h0);
    u_mem.mem[32'h0001_000C] = 32'h0040_0C32;
    core(32'h0030_1000, 1'b1);
    chk("prefetch", pabt, 1'b1);
    bus_rd(mpwf_pkg::ADDR_FAULT_ADDR);
    chk("far_kept", rdv, VA + 1);
    bus_wr(mpwf_pkg::ADDR_FAULT_STATUS, 32'h0);
    bus_rd(mpwf_pkg::ADDR_FAULT_STATUS);
    chk("fsr_kept", rdv[3:0], 4'h1);
    // System bit lets a supervisor read a section whose field is 00
    bus_wr(mpwf_pkg::ADDR_CONTROL, 32'h0000_010F);
    bus_wr(mpwf_pkg::ADDR_DOMAIN_CTRL, 32'h4);
    u_mem.mem[32'h0001_000C] = 32'h0040_0032;
    core(VA, 1'b0);
    chk("sys_read", resp.abort, 1'b0);
    chk("sys_paddr", resp.paddr, 32'h0040_5678);
    // Alignment is still checked with translation off
    bus_wr(mpwf_pkg::ADDR_CONTROL, 32'h0000_0002);
    core(VA + 2, 1'b0);
    chk("align_off", resp.fault_code, mpwf_pkg::FC_ALIGN);
    bus_wr(mpwf_pkg::ADDR_DOMAIN_CTRL, 32'hFFFF_FFFF);
    bus_rd(mpwf_pkg::ADDR_DOMAIN_CTRL);
    chk("dac", rdv, 32'hFFFF_FFFF);
    bus_rd(4'h1);
    chk("unmapped", {rsp, rdv[29:0]}, 32'h8000_0000);
    // Second reset in mid-run clears the records
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    bus_rd(mpwf_pkg::ADDR_DOMAIN_CTRL);
    chk("dac_rst", rdv, mpwf_pkg::DOMAIN_CTRL_RST);
    bus_rd(mpwf_pkg::ADDR_FAULT_ADDR);
    chk("far_rst", rdv, mpwf_pkg::FAULT_ADDR_RST);
    end_sim();
  end
endmodule
bind mpwf_top mpwf_asserts u_asr (.clk_i(clk_i), .reset_i(reset_i), .avs_read_i(avs_read_i),
  .avs_waitrequest_o(avs_waitrequest_o), .core_done_o(core_done_o), .core_resp_o(core_resp_o),
  .core_prefetch_abort_o(core_prefetch_abort_o), .tbl_read_o(tbl_read_o),
  .tbl_addr_o(tbl_addr_o), .tbl_valid_i(tbl_valid_i));
`default_nettype wire
